// >>> common/bcq_if.sv
/*
  Query read link between the host controller and the table.
  Assumes one shared clock; reads answer one cycle after the strobe.
*/
`timescale 1ns/1ns
interface bcq_if;
  logic [8:0] qryAddr;
  logic qryRd;
  logic qryWr;
  logic [15:0] qryWrData;
  logic [15:0] qryData;
  logic qryValid;

  modport dev (input qryAddr, input qryRd, input qryWr, input qryWrData, output qryData, output qryValid);
  modport host (output qryAddr, output qryRd, output qryWr, output qryWrData, input qryData, input qryValid);
endinterface

// >>> common/bcq_pkg.sv
/*
  Package for the burst capability query table: query addresses, stored byte
  values, field positions and the read configuration field layout.
  Assumes a 16-bit data path with the table bytes on the low lanes.
*/
package bcq_pkg;
  localparam int ADDR_W = 9;
  localparam int DATA_W = 16;
  localparam int CODE_W = 3;
  localparam int ENTRY_COUNT = 4;

  localparam logic [ADDR_W-1:0] BURST_CONFIG_ENTRY_COUNT_ADDR = 9'h128;
  localparam logic [ADDR_W-1:0] BURST_CAPABILITY_ENTRY_ONE_ADDR = 9'h129;
  localparam logic [ADDR_W-1:0] BURST_CAPABILITY_ENTRY_TWO_ADDR = 9'h12a;
  localparam logic [ADDR_W-1:0] BURST_CAPABILITY_ENTRY_THREE_ADDR = 9'h12b;
  localparam logic [ADDR_W-1:0] BURST_CAPABILITY_ENTRY_FOUR_ADDR = 9'h12c;
  localparam logic [ADDR_W-1:0] PARTITION_REGION_COUNT_ADDR = 9'h12d;
  localparam logic [ADDR_W-1:0] WORD_WIDTH_ADDR = 9'h028;

  localparam logic [7:0] BURST_CONFIG_ENTRY_COUNT_VAL = 8'h04;
  localparam logic [7:0] BURST_CAPABILITY_ENTRY_ONE_VAL = 8'h01;
  localparam logic [7:0] BURST_CAPABILITY_ENTRY_TWO_VAL = 8'h02;
  localparam logic [7:0] BURST_CAPABILITY_ENTRY_THREE_VAL = 8'h03;
  localparam logic [7:0] BURST_CAPABILITY_ENTRY_FOUR_VAL = 8'h07;
  localparam logic [7:0] PARTITION_REGION_COUNT_DEFAULT = 8'h01;
  localparam logic [7:0] WORD_WIDTH_DEFAULT = 8'h01;
  localparam logic [7:0] NO_BURST_VAL = 8'h00;
  localparam logic [7:0] SINGLE_PARTITION_VAL = 8'h00;
  localparam logic [7:0] RESERVED_READ_VAL = 8'h00;

  localparam int CODE_LSB = 0;
  localparam int CODE_MSB = 2;
  localparam logic [CODE_W-1:0] CONTINUOUS_CODE = 3'h7;
  localparam logic [CODE_W-1:0] RCR_BURST_LEN_RESET = 3'h7;
  localparam logic [5:0] MAX_BURST_WORDS_CONT = 6'h00;

  localparam logic [3:0] HREG_CMD = 4'h0;
  localparam logic [3:0] HREG_STATUS = 4'h1;
  localparam logic [3:0] HREG_COUNT = 4'h2;
  localparam logic [3:0] HREG_CODES = 4'h3;
  localparam logic [3:0] HREG_RCR = 4'h4;
  localparam logic [3:0] HREG_PART = 4'h5;
  localparam logic [3:0] HREG_WIDTH = 4'h6;

  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_BURST_OK = 2;
  localparam int ST_SINGLE_PART = 3;
  localparam int ST_CONT_OK = 4;
  localparam int CMD_START = 0;
  localparam int CMD_SEL_LSB = 4;
  localparam int CMD_SEL_MSB = 5;
endpackage

// >>> logic/bcq_host.sv
/*
  Host memory controller end: walks the burst capability part of the query
  table, checks the entry count and partition count, and copies a chosen
  capability code into its read configuration setting.
  Assumes the device answers each query read in the following cycle.
*/
`timescale 1ns/1ns
module bcq_host (
  input wire logic clk,
  input wire logic resetn,
  bcq_if.host link,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData
);
  typedef enum logic [4:0] {
    IDLE = 5'h01,
    RD_WIDTH = 5'h02,
    RD_COUNT = 5'h04,
    RD_ENTRY = 5'h08,
    RD_PART = 5'h10
  } bcq_state_e;

  bcq_state_e state_ff;
  bcq_state_e nxt_state;
  logic [2:0] idx_ff;
  logic waiting_ff;
  logic busy_ff;
  logic done_ff;
  logic [7:0] count_ff;
  logic [7:0] width_ff;
  logic [7:0] part_ff;
  logic [11:0] codes_ff;
  logic [2:0] rcr_ff;
  logic [1:0] sel_ff;
  logic [31:0] rdData_ff;
  logic [8:0] addr_ff;
  logic rd_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Query sequencer
  function automatic logic [8:0] entryAddr(input logic [2:0] i);
    entryAddr = bcq_pkg::BURST_CAPABILITY_ENTRY_ONE_ADDR + {6'h00, i};
  endfunction

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      IDLE:
        if (regWr && regAddr == bcq_pkg::HREG_CMD && regWrData[bcq_pkg::CMD_START])
          nxt_state = RD_WIDTH;
      RD_WIDTH:
        if (link.qryValid)
          nxt_state = RD_COUNT;
      RD_COUNT:
        if (link.qryValid)
        begin
          if (link.qryData[7:0] == bcq_pkg::NO_BURST_VAL)
            nxt_state = RD_PART;
          else
            nxt_state = RD_ENTRY;
        end
      RD_ENTRY:
        if (link.qryValid && (idx_ff == 3'(bcq_pkg::ENTRY_COUNT - 1) || {5'h00, idx_ff} + 8'h01 >= count_ff))
          nxt_state = RD_PART;
      RD_PART:
        if (link.qryValid)
          nxt_state = IDLE;
      default:
        nxt_state = IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      state_ff <= IDLE;
    else
      state_ff <= nxt_state;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      rd_ff <= 1'b0;
      addr_ff <= 9'h000;
      waiting_ff <= 1'b0;
    end
    else if (state_ff != IDLE && !waiting_ff)
    begin
      rd_ff <= 1'b1;
      waiting_ff <= 1'b1;
      case (state_ff)
        RD_WIDTH: addr_ff <= bcq_pkg::WORD_WIDTH_ADDR; // R9
        RD_COUNT: addr_ff <= bcq_pkg::BURST_CONFIG_ENTRY_COUNT_ADDR;
        RD_ENTRY: addr_ff <= entryAddr(idx_ff);
        RD_PART: addr_ff <= bcq_pkg::PARTITION_REGION_COUNT_ADDR;
        default: addr_ff <= addr_ff;
      endcase
    end
    else
    begin
      rd_ff <= 1'b0;
      if (link.qryValid)
        waiting_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Captured table values
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      idx_ff <= 3'h0;
      count_ff <= 8'h00;
      width_ff <= 8'h00;
      part_ff <= 8'h00;
      codes_ff <= 12'h000;
    end
    else if (link.qryValid)
    begin
      case (state_ff)
        RD_WIDTH: width_ff <= link.qryData[7:0]; // R9
        RD_COUNT:
        begin
          count_ff <= link.qryData[7:0];
          idx_ff <= 3'h0;
          if (link.qryData[7:0] == bcq_pkg::NO_BURST_VAL)
            codes_ff <= 12'h000; // R2
        end
        RD_ENTRY:
        begin
          codes_ff[idx_ff*3 +: 3] <= link.qryData[bcq_pkg::CODE_MSB:bcq_pkg::CODE_LSB]; // R3
          idx_ff <= idx_ff + 3'h1;
        end
        RD_PART: part_ff <= link.qryData[7:0]; // R11
        default: idx_ff <= idx_ff;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end
    else
    begin
      busy_ff <= nxt_state != IDLE;
      if (state_ff == RD_PART && link.qryValid)
        done_ff <= 1'b1;
      else if (nxt_state == RD_WIDTH && state_ff == IDLE)
        done_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read configuration burst length
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      sel_ff <= 2'h0;
      rcr_ff <= bcq_pkg::RCR_BURST_LEN_RESET;
    end
    else if (regWr && regAddr == bcq_pkg::HREG_CMD)
      sel_ff <= regWrData[bcq_pkg::CMD_SEL_MSB:bcq_pkg::CMD_SEL_LSB];
    else if (done_ff && count_ff != bcq_pkg::NO_BURST_VAL && {6'h00, sel_ff} < count_ff)
      rcr_ff <= codes_ff[sel_ff*3 +: 3]; // R5
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software register port
  always_ff @(posedge clk)
  begin
    if (!resetn)
      rdData_ff <= 32'h0000_0000;
    else if (regRd)
    begin
      case (regAddr)
        bcq_pkg::HREG_STATUS:
          rdData_ff <= {27'h0, codes_ff[9 +: 3] == bcq_pkg::CONTINUOUS_CODE && count_ff == 8'(bcq_pkg::ENTRY_COUNT),
                        part_ff == bcq_pkg::SINGLE_PARTITION_VAL, count_ff != bcq_pkg::NO_BURST_VAL,
                        done_ff, busy_ff}; // R2 R11
        bcq_pkg::HREG_COUNT: rdData_ff <= {24'h000000, count_ff};
        bcq_pkg::HREG_CODES: rdData_ff <= {20'h00000, codes_ff};
        bcq_pkg::HREG_RCR: rdData_ff <= {29'h0, rcr_ff};
        bcq_pkg::HREG_PART: rdData_ff <= {24'h000000, part_ff};
        bcq_pkg::HREG_WIDTH: rdData_ff <= {24'h000000, width_ff};
        default: rdData_ff <= 32'h0000_0000;
      endcase
    end
    else
      rdData_ff <= 32'h0000_0000;
  end

  assign regRdData = rdData_ff;
  assign link.qryAddr = addr_ff;
  assign link.qryRd = rd_ff;
  assign link.qryWr = 1'b0;
  assign link.qryWrData = 16'h0000;
endmodule // bcq_host

// >>> logic/bcq_table.sv
/*
  Device end: read-only burst capability and partition region count bytes
  of the query table, answered on the low data lanes.
  Assumes a host that strobes one read at a time on the shared clock.
*/
// Functional notes
// R1: Count location reads four entries
// R2: Zero count means no burst support
// R3: Entry low three bits code, rest reserved
// R4: Code seven means continuous linear burst
// R5: Host copies code into read configuration
// R6: Entries one, two read codes 1, 2
// R7: Entry three reads code three
// R8: Entry four reads code seven
// R9: Host checks word width for output width
// R10: Partition region count location reports regions
// R11: Zero regions means single partition device
// R12: Table read-only; writes ignored
`timescale 1ns/1ns
module bcq_table #(
  parameter logic [7:0] PARTITION_REGIONS = bcq_pkg::PARTITION_REGION_COUNT_DEFAULT,
  parameter logic [7:0] WORD_WIDTH_CODE = bcq_pkg::WORD_WIDTH_DEFAULT
) (
  input wire logic clk,
  input wire logic resetn,
  bcq_if.dev link,
  output logic continuousBurst
);
  logic [15:0] data_ff;
  logic valid_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Table lookup
  function automatic logic [7:0] lookup(input logic [8:0] a);
    case (a)
      bcq_pkg::BURST_CONFIG_ENTRY_COUNT_ADDR: lookup = bcq_pkg::BURST_CONFIG_ENTRY_COUNT_VAL; // R1
      bcq_pkg::BURST_CAPABILITY_ENTRY_ONE_ADDR: lookup = bcq_pkg::BURST_CAPABILITY_ENTRY_ONE_VAL; // R6
      bcq_pkg::BURST_CAPABILITY_ENTRY_TWO_ADDR: lookup = bcq_pkg::BURST_CAPABILITY_ENTRY_TWO_VAL; // R6
      bcq_pkg::BURST_CAPABILITY_ENTRY_THREE_ADDR: lookup = bcq_pkg::BURST_CAPABILITY_ENTRY_THREE_VAL; // R7
      bcq_pkg::BURST_CAPABILITY_ENTRY_FOUR_ADDR: lookup = bcq_pkg::BURST_CAPABILITY_ENTRY_FOUR_VAL; // R8
      bcq_pkg::PARTITION_REGION_COUNT_ADDR: lookup = PARTITION_REGIONS; // R10
      bcq_pkg::WORD_WIDTH_ADDR: lookup = WORD_WIDTH_CODE;
      default: lookup = bcq_pkg::RESERVED_READ_VAL;
    endcase
  endfunction

  // Reads only; write strobe and data never reach the stored bytes
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      data_ff <= 16'h0000;
      valid_ff <= 1'b0;
    end
    else
    begin
      valid_ff <= link.qryRd; // R12
      data_ff <= link.qryRd ? {8'h00, lookup(link.qryAddr)} : 16'h0000; // R12 R3
    end
  end

  // Last entry advertises the endless linear burst
  assign continuousBurst = lookup(bcq_pkg::BURST_CAPABILITY_ENTRY_FOUR_ADDR) == {5'h00, bcq_pkg::CONTINUOUS_CODE}; // R4
  assign link.qryData = data_ff;
  assign link.qryValid = valid_ff;
endmodule // bcq_table

// >>> verification/bcq_table_assertions.sv
/*
  Checker for the query link of the burst capability table.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ns
module bcq_table_assertions #(
  parameter logic [7:0] PART = 8'h00
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [8:0] qryAddr,
  input wire logic qryRd,
  input wire logic qryWr,
  input wire logic [15:0] qryWrData,
  input wire logic [15:0] qryData,
  input wire logic qryValid,
  input wire logic continuousBurst
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////////////
  sequence rdAt(logic [8:0] a);
    qryRd && qryAddr == a;
  endsequence
  property answers(logic [8:0] a, logic [15:0] v);
    rdAt(a) |=> qryValid && qryData == v;
  endproperty
  ////////////////////////////////////////////////////////////////////////////////
  chk_valid_after_read: assert property (qryRd |=> qryValid) else $error("read unanswered");
  chk_no_spurious_valid: assert property (!qryRd |=> !qryValid) else $error("answer without read");
  chk_count_four: assert property (answers(9'h128, 16'h0004)) else $error("bad count");
  chk_entry_one_code: assert property (answers(9'h129, 16'h0001)) else $error("bad entry 1");
  chk_entry_two_code: assert property (answers(9'h12a, 16'h0002)) else $error("bad entry 2");
  chk_entry_three_code: assert property (answers(9'h12b, 16'h0003)) else $error("bad entry 3");
  chk_entry_four_code: assert property (answers(9'h12c, 16'h0007)) else $error("bad entry 4");
  chk_reserved_bits_zero: assert property (qryRd && qryAddr inside {[9'h129:9'h12c]}
    |=> qryData[15:3] == 13'h0) else $error("reserved bits set");
  chk_part_count: assert property (answers(9'h12d, {8'h00, PART})) else $error("bad regions");
  chk_cont_level: assert property (continuousBurst) else $error("continuous flag low");
  chk_idle_lanes_zero: assert property (!qryValid |-> qryData == 16'h0000) else $error("data off read");
endmodule // bcq_table_assertions

// >>> verification/burst_capability_query_table_tb_top.sv
/*
  Testbench: host and table joined by the query link, driven through the
  host register port. Assumes one 25 MHz clock and synchronous reset.
*/
`timescale 1ns/1ns
module burst_capability_query_table_tb_top;
  logic clk;
  logic resetn;
  logic [3:0] regAddr;
  logic [31:0] regWrData;
  logic regWr;
  logic regRd;
  logic [31:0] regRdData;
  logic [31:0] rd;
  logic cont;
  logic [2:0] codes [4];
  int n_mismatch;
  int total_checks;
  bcq_if bcq_if_i ();
  bcq_table #(.PARTITION_REGIONS(8'h00), .WORD_WIDTH_CODE(8'h01)) bcq_table_i (.clk(clk), .resetn(resetn),
    .link(bcq_if_i), .continuousBurst(cont));
  bcq_host bcq_host_i (.clk(clk), .resetn(resetn), .link(bcq_if_i), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData));
  bcq_table_assertions #(.PART(8'h00)) bcq_table_assertions_i (.clk(clk), .resetn(resetn),
    .qryAddr(bcq_if_i.qryAddr), .qryRd(bcq_if_i.qryRd), .qryWr(bcq_if_i.qryWr), .qryWrData(bcq_if_i.qryWrData),
    .qryData(bcq_if_i.qryData), .qryValid(bcq_if_i.qryValid), .continuousBurst(cont));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic regWrite(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic regRead(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 d = regRdData;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    conclude();
  end
  initial
  begin
    codes = '{3'h1, 3'h2, 3'h3, 3'h7};
    resetn = 1'b0;
    regAddr = 4'h0;
    regWrData = 32'h00000000;
    regWr = 1'b0;
    regRd = 1'b0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    regRead(bcq_pkg::HREG_RCR, rd);
    chk(rd, 32'h00000007);
    chk({31'h0, cont}, 32'h00000001);
    $display("test reset done");
    regWrite(bcq_pkg::HREG_CMD, 32'h00000001);
    for (int i = 0; i < 60; i++)
    begin
      regRead(bcq_pkg::HREG_STATUS, rd);
      if (rd[1] === 1'b1)
        break;
    end
    chk(rd, 32'h0000001e);
    regRead(bcq_pkg::HREG_COUNT, rd);
    chk(rd, 32'h00000004);
    regRead(bcq_pkg::HREG_CODES, rd);
    chk(rd, 32'h00000ed1);
    regRead(bcq_pkg::HREG_PART, rd);
    chk(rd, 32'h00000000);
    regRead(bcq_pkg::HREG_WIDTH, rd);
    chk(rd, 32'h00000001);
    regRead(4'hf, rd);
    chk(rd, 32'h00000000);
    $display("test scan done");
    for (int i = 0; i < 4; i++)
    begin
      regWrite(bcq_pkg::HREG_CMD, {26'h0, 2'(i), 4'h0});
      repeat (2) @(posedge clk);
      regRead(bcq_pkg::HREG_RCR, rd);
      chk(rd, {29'h0, codes[i]});
    end
    $display("test copy done");
    conclude();
  end
endmodule // burst_capability_query_table_tb_top
